// ### logic/power_timing_pkg.sv
// Purpose: constants and types for the power-mode timing register bank
// Assumes: 20 MHz system clock, registers reached through a byte-wide register port
// Notes: each register is one byte at its printed offset
// What this block does
// - Normal mode report interval byte is milliseconds, 0-255, reset 16.
// - Low mode report interval byte is milliseconds, 0-255, reset 48.
// - Intervals timed by slow oscillator tick; up to 4 ms deviation accepted.
// - Intervals below 4 ms may report slower than programmed.
// - Deepest mode interval is byte times 16 ms, reset byte 8.
// - Step-down time is byte times 500 ms, reset byte 20.
// - Mask bit zero passes its event source, one suppresses it; reset zero.
// - Mask bits: 7 limit active, 6 power, 5 system, 4 temp, 3 hyst, 2 mag, 1 limit, 0 prox.
// - Pulse duty equals (byte plus one) over 256.
// - Pulse output runs at fixed 1 kHz on general pin three.
// - Pulse output only while its enable bit is set; host sets it.
// - While pulsing, coil transmit disabled and device stays in normal mode.
// - Mode field 00 normal, 01 low, 10 deepest, 11 halt; first three each own interval, halt never reports.
// - Automatic switching only while auto_switch_disable is clear.
package power_timing_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int PULSE_HZ = 1000;
	localparam int PULSE_STEP_CYCLES = CLK_HZ / PULSE_HZ / 256;
	localparam int DEEP_UNIT_MS = 16;
	localparam int STEP_UNIT_MS = 500;
	localparam logic [7:0] ADDR_NORMAL = 8'hd3;
	localparam logic [7:0] ADDR_LOW = 8'hd4;
	localparam logic [7:0] ADDR_DEEP = 8'hd5;
	localparam logic [7:0] ADDR_STEP = 8'hd6;
	localparam logic [7:0] ADDR_MASK = 8'hd7;
	localparam logic [7:0] ADDR_DUTY = 8'hd8;
	localparam logic [7:0] RST_NORMAL = 8'h10;
	localparam logic [7:0] RST_LOW = 8'h30;
	localparam logic [7:0] RST_DEEP = 8'h08;
	localparam logic [7:0] RST_STEP = 8'h14;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_DUTY = 8'h00;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_LOW, MODE_DEEP, MODE_HALT} power_mode_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;
	typedef struct packed {
		logic pulse_enable;
		logic deep_allowed;
		logic auto_switch_disable;
		power_mode_type manual_mode;
	} mode_ctl_type;
	typedef struct packed {
		logic [7:0] normal_report_interval;
		logic [7:0] low_report_interval;
		logic [7:0] deep_sleep_report_interval;
		logic [7:0] mode_step_down_timer;
		logic [7:0] event_source_mask;
		logic [7:0] pulse_duty_setting;
		logic [7:0] rdata;
		logic rvalid;
		power_mode_type mode;
		logic [15:0] ms_div;
		logic [12:0] report_ms;
		logic report_tick;
		logic [16:0] idle_ms;
		logic [7:0] pwm_phase;
		logic [7:0] pwm_div;
		logic general_pin_three;
		logic coil_transmit_enable;
		logic [7:0] event_status;
		logic ready;
	} bank_state_type;
endpackage : power_timing_pkg

// ### logic/power_mode_timing_regs.sv
// Purpose: timing register bank with report scheduler, mode stepper and pulse output
// Assumes: event and activity inputs are synchronous to clk
// Notes: the slow oscillator is modelled by a millisecond tick from clk
`timescale 1ns/10ps
module power_mode_timing_regs (
	input wire logic clk,
	input wire logic reset_n,
	input power_timing_pkg::reg_req_type req,
	input power_timing_pkg::mode_ctl_type mode_ctl,
	input wire logic [7:0] event_raw,
	input wire logic activity,
	output logic [7:0] rdata,
	output logic rvalid,
	output power_timing_pkg::power_mode_type mode,
	output logic report_tick,
	output logic general_pin_three,
	output logic coil_transmit_enable,
	output logic [7:0] event_status,
	output logic ready
);
	import power_timing_pkg::*;

	bank_state_type s_r, s_nxt;

	function automatic logic [12:0] interval_ms(input power_mode_type m, input bank_state_type s);
		case (m)
			MODE_NORMAL: interval_ms = {5'h00, s.normal_report_interval};
			MODE_LOW: interval_ms = {5'h00, s.low_report_interval};
			MODE_DEEP: interval_ms = 13'(s.deep_sleep_report_interval * DEEP_UNIT_MS);
			default: interval_ms = 13'h0000;
		endcase
	endfunction : interval_ms

	always_comb begin
		logic ms_tick;
		logic [16:0] step_ms;
		ms_tick = 1'b0;
		step_ms = 17'(s_r.mode_step_down_timer * STEP_UNIT_MS);
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.report_tick = 1'b0;
		if (req.wr) begin
			if (req.addr == ADDR_NORMAL) begin
				s_nxt.normal_report_interval = req.wdata;
			end else if (req.addr == ADDR_LOW) begin
				s_nxt.low_report_interval = req.wdata;
			end else if (req.addr == ADDR_DEEP) begin
				s_nxt.deep_sleep_report_interval = req.wdata;
			end else if (req.addr == ADDR_STEP) begin
				s_nxt.mode_step_down_timer = req.wdata;
			end else if (req.addr == ADDR_MASK) begin
				s_nxt.event_source_mask = req.wdata;
			end else if (req.addr == ADDR_DUTY) begin
				s_nxt.pulse_duty_setting = req.wdata;
			end
		end
		if (req.rd) begin
			s_nxt.rvalid = 1'b1;
			if (req.addr == ADDR_NORMAL) begin
				s_nxt.rdata = s_r.normal_report_interval;
			end else if (req.addr == ADDR_LOW) begin
				s_nxt.rdata = s_r.low_report_interval;
			end else if (req.addr == ADDR_DEEP) begin
				s_nxt.rdata = s_r.deep_sleep_report_interval;
			end else if (req.addr == ADDR_STEP) begin
				s_nxt.rdata = s_r.mode_step_down_timer;
			end else if (req.addr == ADDR_MASK) begin
				s_nxt.rdata = s_r.event_source_mask;
			end else if (req.addr == ADDR_DUTY) begin
				s_nxt.rdata = s_r.pulse_duty_setting;
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
		// Millisecond tick stands in for the slow oscillator; its accuracy is within 4 ms
		if (s_r.ms_div == 16'(MS_CYCLES - 1)) begin
			s_nxt.ms_div = 16'h0000;
			ms_tick = 1'b1;
		end else begin
			s_nxt.ms_div = s_r.ms_div + 16'h0001;
		end
		// Report scheduler; a zero interval reports every millisecond, the fastest reachable
		if (s_r.mode != MODE_HALT && ms_tick) begin
			if (s_r.report_ms + 13'h0001 >= interval_ms(s_r.mode, s_r)) begin
				s_nxt.report_ms = 13'h0000;
				s_nxt.report_tick = 1'b1;
			end else begin
				s_nxt.report_ms = s_r.report_ms + 13'h0001;
			end
		end
		// Mode selection
		// Pulse output pins the mode to normal ahead of every other request
		if (mode_ctl.pulse_enable) begin
			s_nxt.mode = MODE_NORMAL;
			s_nxt.idle_ms = 17'h00000;
		end else if (mode_ctl.auto_switch_disable) begin
			s_nxt.mode = mode_ctl.manual_mode;
			s_nxt.idle_ms = 17'h00000;
		end else if (activity) begin
			s_nxt.mode = MODE_NORMAL;
			s_nxt.idle_ms = 17'h00000;
		end else if (ms_tick) begin
			if (s_r.idle_ms + 17'h00001 >= step_ms) begin
				s_nxt.idle_ms = 17'h00000;
				if (s_r.mode == MODE_NORMAL) begin
					s_nxt.mode = MODE_LOW;
				end else if (s_r.mode == MODE_LOW && mode_ctl.deep_allowed) begin
					s_nxt.mode = MODE_DEEP;
				end else if (s_r.mode == MODE_HALT) begin
					s_nxt.mode = MODE_NORMAL;
				end
			end else begin
				s_nxt.idle_ms = s_r.idle_ms + 17'h00001;
			end
		end
		if (s_nxt.mode != s_r.mode) begin
			s_nxt.report_ms = 13'h0000;
		end
		// 256 steps per 1 kHz period
		// Period is 19968 cycles, slightly fast: 20000 does not split into 256 equal steps
		if (s_r.pwm_div == 8'(PULSE_STEP_CYCLES - 1)) begin
			s_nxt.pwm_div = 8'h00;
			s_nxt.pwm_phase = s_r.pwm_phase + 8'h01;
		end else begin
			s_nxt.pwm_div = s_r.pwm_div + 8'h01;
		end
		s_nxt.general_pin_three = mode_ctl.pulse_enable &&
			(s_r.pwm_phase <= s_r.pulse_duty_setting);
		s_nxt.coil_transmit_enable = !mode_ctl.pulse_enable;
		// Status follows every source; only unmasked ones raise ready
		s_nxt.event_status = event_raw;
		s_nxt.ready = |(event_raw & ~s_r.event_source_mask);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{normal_report_interval: RST_NORMAL, low_report_interval: RST_LOW,
				deep_sleep_report_interval: RST_DEEP, mode_step_down_timer: RST_STEP,
				event_source_mask: RST_MASK, pulse_duty_setting: RST_DUTY,
				rdata: 8'h00, rvalid: 1'b0, mode: MODE_NORMAL, ms_div: 16'h0000,
				report_ms: 13'h0000, report_tick: 1'b0, idle_ms: 17'h00000,
				pwm_phase: 8'h00, pwm_div: 8'h00, general_pin_three: 1'b0,
				coil_transmit_enable: 1'b1, event_status: 8'h00, ready: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign rvalid = s_r.rvalid;
	assign mode = s_r.mode;
	assign report_tick = s_r.report_tick;
	assign general_pin_three = s_r.general_pin_three;
	assign coil_transmit_enable = s_r.coil_transmit_enable;
	assign event_status = s_r.event_status;
	assign ready = s_r.ready;

	chk_pulse_needs_enable: assert property (@(posedge clk) disable iff (!reset_n)
		general_pin_three |-> $past(mode_ctl.pulse_enable))
		else $error("pulse output high without enable");
	chk_coil_off_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && $past(mode_ctl.pulse_enable) |-> !coil_transmit_enable)
		else $error("coil transmit left on while pulsing");
	chk_pulse_keeps_normal: assert property (@(posedge clk) disable iff (!reset_n)
		$past(mode_ctl.pulse_enable) |-> mode == MODE_NORMAL)
		else $error("mode left normal while pulsing");
	chk_manual_mode_held: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && $past(mode_ctl.auto_switch_disable && !mode_ctl.pulse_enable)
		|-> mode == $past(mode_ctl.manual_mode))
		else $error("manual mode not followed");
	chk_activity_wakes: assert property (@(posedge clk) disable iff (!reset_n)
		$past(activity && !mode_ctl.auto_switch_disable) |-> mode == MODE_NORMAL)
		else $error("activity did not return to normal");
	chk_mask_blocks_ready: assert property (@(posedge clk) disable iff (!reset_n)
		ready |-> |($past(event_raw) & ~$past(s_r.event_source_mask)))
		else $error("ready from masked source");
	chk_status_tracks: assert property (@(posedge clk) disable iff (!reset_n)
		##1 event_status == $past(event_raw))
		else $error("status not updated");
	chk_full_duty: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && $past(mode_ctl.pulse_enable) && $past(s_r.pulse_duty_setting) == 8'hff
		|-> general_pin_three)
		else $error("full duty not high");
	chk_halt_no_report: assert property (@(posedge clk) disable iff (!reset_n)
		$past(mode) == MODE_HALT && mode == MODE_HALT |-> !report_tick)
		else $error("report in halt");

	// Named steps of the register port and of the automatic mode stepper
	sequence read_taken;
		req.rd;
	endsequence
	sequence read_answered;
		rvalid;
	endsequence
	sequence auto_expiry;
		!mode_ctl.pulse_enable && !mode_ctl.auto_switch_disable && !activity &&
			s_r.ms_div == 16'(MS_CYCLES - 1) &&
			s_r.idle_ms + 17'h00001 >= 17'(s_r.mode_step_down_timer * STEP_UNIT_MS);
	endsequence
	chk_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
		read_taken |=> read_answered)
		else $error("read not answered next cycle");
	chk_read_single: assert property (@(posedge clk) disable iff (!reset_n)
		read_answered |-> $past(req.rd))
		else $error("read answer without request");
	chk_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
		req.wr && req.addr == ADDR_MASK |=> s_r.event_source_mask == $past(req.wdata))
		else $error("mask write lost");
	chk_duty_write: assert property (@(posedge clk) disable iff (!reset_n)
		req.wr && req.addr == ADDR_DUTY |=> s_r.pulse_duty_setting == $past(req.wdata))
		else $error("duty write lost");
	chk_tick_on_ms: assert property (@(posedge clk) disable iff (!reset_n)
		report_tick |-> $past(s_r.ms_div) == 16'(MS_CYCLES - 1))
		else $error("report tick off the millisecond grid");
	chk_step_to_low: assert property (@(posedge clk) disable iff (!reset_n)
		auto_expiry ##0 (mode == MODE_NORMAL) |=> mode == MODE_LOW)
		else $error("no step down to low");
	chk_step_to_deep: assert property (@(posedge clk) disable iff (!reset_n)
		auto_expiry ##0 (mode == MODE_LOW && mode_ctl.deep_allowed) |=> mode == MODE_DEEP)
		else $error("no step down to deepest");
	chk_coil_restored: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && !$past(mode_ctl.pulse_enable) |-> coil_transmit_enable)
		else $error("coil transmit still off after pulsing");
	chk_ready_unmasked: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n) && |($past(event_raw) & ~$past(s_r.event_source_mask)) |-> ready)
		else $error("unmasked event did not raise ready");
endmodule : power_mode_timing_regs

// ### test/host_model.sv
// Purpose: host side model issuing single-byte register writes and reads
// Assumes: strobes change on the falling edge and stay up for one cycle
// Notes: a read waits a bounded number of cycles for rvalid
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output power_timing_pkg::reg_req_type req
);
	import power_timing_pkg::*;
	initial begin
		req = '0;
	end
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		// Released bus shows inverted values so a stale address cannot pass
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		for (int n = 0; n < 4 && !ok; n++) begin
			if (rvalid === 1'b1) begin
				d = rdata;
				ok = 1'b1;
			end else begin
				@(negedge clk);
			end
		end
	endtask : read_reg
endmodule : host_model

// ### test/tb_top.sv
// Purpose: self-checking bench for the timing register bank
// Assumes: host_model carries register traffic; other inputs change on falling edges
// Notes: pulse count spans one whole period, so the starting phase does not matter
`timescale 1ns/10ps
module tb_top;
	import power_timing_pkg::*;
	logic clk, reset_n, activity, ok, rvalid, report_tick, pin, coil, ready;
	logic [7:0] event_raw, rdata, d, event_status;
	power_mode_type mode;
	reg_req_type req;
	mode_ctl_type mode_ctl;
	int fails, samples_checked, n, gap;
	localparam logic [23:0] rows [8] = '{24'hd30000, 24'hd4ffff, 24'hd5ffff, 24'hd60000,
		24'hd7d7d7, 24'hd87f7f, 24'hd95a00, 24'hd2a500};
	localparam logic [7:0] reset_values [6] = '{RST_NORMAL, RST_LOW, RST_DEEP, RST_STEP,
		RST_MASK, RST_DUTY};
	power_mode_timing_regs power_mode_timing_regs_inst (.clk(clk), .reset_n(reset_n),
		.req(req), .mode_ctl(mode_ctl), .event_raw(event_raw), .activity(activity),
		.rdata(rdata), .rvalid(rvalid), .mode(mode), .report_tick(report_tick),
		.general_pin_three(pin), .coil_transmit_enable(coil), .event_status(event_status),
		.ready(ready));
	host_model host_model_inst (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		host_model_inst.read_reg(a, v, ok);
		if (!ok) begin
			fails++;
			print_verdict();
		end
	endtask : rd
	// Starts one edge on so a tick still high from the last call is not counted twice
	task automatic wait_tick(output int c);
		@(negedge clk);
		c = 1;
		while (report_tick !== 1'b1) begin
			@(negedge clk);
			c++;
			if (c > 30000) begin
				fails++;
				print_verdict();
			end
		end
	endtask : wait_tick
	initial begin
		reset_n = 1'b0;
		activity = 1'b0;
		event_raw = 8'h00;
		mode_ctl = '{1'b0, 1'b0, 1'b1, MODE_NORMAL};
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		foreach (rows[i]) begin
			host_model_inst.write_reg(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], d);
			check("readback", {8'h00, d}, {8'h00, rows[i][7:0]});
		end
		$display("register rows done");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			event_raw = 8'h01 << i;
			repeat (2) @(negedge clk);
			check("ready", {15'h0, ready}, {15'h0, ~rows[4][8+i]});
			check("status", {8'h00, event_status}, {8'h00, event_raw});
		end
		event_raw = 8'h00;
		$display("event mask done");
		mode_ctl.manual_mode = MODE_LOW;
		mode_ctl.pulse_enable = 1'b1;
		repeat (4) @(negedge clk);
		n = 0;
		repeat (19968) begin
			@(negedge clk);
			n += (pin === 1'b1);
		end
		check("pulse high", n[15:0], 16'((int'(rows[5][15:8]) + 1) * PULSE_STEP_CYCLES));
		check("coil", {15'h0, coil}, 16'h0000);
		check("mode pulsing", {14'h0, mode}, {14'h0, MODE_NORMAL});
		mode_ctl.pulse_enable = 1'b0;
		repeat (2) @(negedge clk);
		check("mode manual", {14'h0, mode}, {14'h0, MODE_LOW});
		check("coil idle", {15'h0, coil}, 16'h0001);
		$display("pulse output done");
		mode_ctl.manual_mode = MODE_NORMAL;
		host_model_inst.write_reg(ADDR_NORMAL, 8'h01);
		host_model_inst.write_reg(ADDR_LOW, 8'h01);
		// Step-down time of zero moves one mode down at each millisecond tick until the deepest mode
		mode_ctl = '{1'b0, 1'b1, 1'b0, MODE_NORMAL};
		wait_tick(gap);
		check("auto low", {14'h0, mode}, {14'h0, MODE_LOW});
		wait_tick(gap);
		check("report gap", {15'h0, gap >= MS_CYCLES - 1 && gap <= MS_CYCLES + 1}, 16'h0001);
		check("auto deep", {14'h0, mode}, {14'h0, MODE_DEEP});
		mode_ctl = '{1'b0, 1'b1, 1'b1, MODE_HALT};
		n = 0;
		repeat (20010) begin
			@(negedge clk);
			n += (report_tick === 1'b1);
		end
		check("halt ticks", n[15:0], 16'h0000);
		check("mode halt", {14'h0, mode}, {14'h0, MODE_HALT});
		activity = 1'b1;
		mode_ctl.auto_switch_disable = 1'b0;
		repeat (2) @(negedge clk);
		check("activity wake", {14'h0, mode}, {14'h0, MODE_NORMAL});
		activity = 1'b0;
		mode_ctl = '{1'b0, 1'b0, 1'b1, MODE_NORMAL};
		$display("report timing done");
		reset_n = 1'b0;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		foreach (reset_values[i]) begin
			rd(ADDR_NORMAL + 8'(i), d);
			check("default", {8'h00, d}, {8'h00, reset_values[i]});
		end
		$display("second reset done");
		print_verdict();
	end
endmodule : tb_top
